// file: shared/rcpt_pkg.sv
// Package for the reset-cause and power-up timer block.
// Assumes a single 40 MHz clock and an Avalon-MM slave of 32-bit words.
package rcpt_pkg;

  // Bus geometry and register byte offsets
  localparam int         ADDR_W       = 4;
  localparam int         DATA_W       = 32;
  localparam logic [3:0] REG_STATUS   = 4'h0;
  localparam logic [3:0] REG_CTRL     = 4'h4;
  localparam logic [3:0] REG_TIMER    = 4'h8;
  localparam logic [3:0] REG_SCRATCH  = 4'hC;

  // Cause and stack flag positions in the status word
  localparam int FLG_BROWNOUT  = 0;
  localparam int FLG_POWERON   = 1;
  localparam int FLG_POWERDOWN = 2;
  localparam int FLG_WDT       = 3;
  localparam int FLG_RSTINSTR  = 4;
  localparam int FLG_CFGMIS    = 5;
  localparam int FLG_STKUDF    = 6;
  localparam int FLG_STKOVF    = 7;

  // Flag values forced by power events, and bits software may write
  localparam logic [7:0] FLAGS_POR    = 8'h3C;
  localparam logic [7:0] FLAGS_SW_MSK = 8'hF3;

  // Control register layout and reset value
  localparam int   CTRL_SERE_BIT  = 0;
  localparam logic CTRL_SERE_RST  = 1'b1;

  // Timer status word layout
  localparam int TMR_INRST_BIT  = 16;
  localparam int TMR_STATE_LSB  = 17;

  // Program counter values
  localparam int          PC_W      = 21;
  localparam logic [20:0] PC_ZERO   = 21'h000000;
  localparam logic [20:0] PC_STEP   = 21'h000002;
  localparam logic [20:0] VEC_HIGH  = 21'h000008;
  localparam logic [20:0] VEC_LOW   = 21'h000018;

  // Power-up timer: 11 bits, 2048 internal oscillator periods
  localparam int           PUTM_W    = 11;
  localparam logic [10:0]  PUTM_ZERO = 11'h000;
  localparam logic [10:0]  PUTM_ONE  = 11'h001;
  localparam logic [10:0]  PUTM_LAST = 11'h7FF;

  // Configuration word width
  localparam int CFG_W = 16;

  // Power-managed mode encoding
  localparam logic [1:0] PM_FULL = 2'h0;
  localparam logic [1:0] PM_RUN  = 2'h1;
  localparam logic [1:0] PM_IDLE = 2'h2;

  // Sequencer states, Gray along power -> timer -> run
  typedef enum logic [1:0] {
    ST_POWER = 2'b00,
    ST_TIMER = 2'b01,
    ST_RUN   = 2'b11,
    ST_HOLD  = 2'b10
  } rcpt_state_e;

endpackage : rcpt_pkg

// file: src/rcpt_top.sv
// Reset sequencer, reset-cause flags and power-up timer of the core.
// Assumes all event inputs are synchronous one-cycle pulses or levels
// and that the internal oscillator period arrives as a one-cycle tick.
//
// Implementation choices: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps

// Function
// - Brown-out flag cleared on every brown-out and power-on reset.
// - Regulator off disables brown-out; power-on still clears brown-out flag.
// - Active configuration continuously compared against complemented shadow.
// - Mismatch issues a reset and clears the mismatch flag.
// - Mismatch flag set by power-on and brown-out, unchanged by every other reset source except mismatch.
// - Every hard or power reset reloads configuration from stored words.
// - Power-up timer always enabled, no disable option.
// - 11-bit timer counts 2048 oscillator ticks, core held in reset.
// - Timer starts only after the power-on pulse is released.
// - Master clear held past timer expiry starts execution on release.
// - Registers without reset value keep contents through all resets.
// - Power-on: PC zero, four flags one, power/brown/stack flags zero.
// - Master clear in run modes sets watchdog flag, PC zero.
// - Master clear in idle or sleep sets watchdog, clears power-down.
// - Watchdog in full or run mode resets, clears watchdog flag.
// - Master clear at full power restarts, all flags unchanged.
// - Stack full with error resets enabled resets and sets flag.
// - Underflow sets flag and PC zero; resets only when enabled.
// - Watchdog in idle or sleep wakes at PC+2, clears two flags.
// - Interrupt wake continues at PC+2, clears power-down flag only.
// - Interrupt wake with a global enable loads vector 0008h or 0018h.
// - Watchdog wake keeps register contents, no reset.
// - Reset instruction resets and clears its flag; software sets it.
// - Supply dip during timer returns to brown-out, timer reinitialised.
module rcpt_top
  import rcpt_pkg::*;
(
  // Clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_reset,
  // Supply and pin events
  input  wire logic              i_power_on,
  input  wire logic              i_brownout,
  input  wire logic              i_vreg_enable,
  input  wire logic              i_master_clear_pin_n,
  input  wire logic              i_internal_rc_osc_tick,
  // Core events
  input  wire logic [1:0]        i_pm_mode,
  input  wire logic              i_watchdog_expiry,
  input  wire logic              i_reset_instr,
  input  wire logic              i_clrwdt_instr,
  input  wire logic              i_sleep_instr,
  input  wire logic              i_stack_full,
  input  wire logic              i_stack_underflow,
  input  wire logic              i_irq_wake,
  input  wire logic              i_irq_wake_high,
  input  wire logic              i_high_prio_global_irq_en,
  input  wire logic              i_low_prio_global_irq_en,
  input  wire logic [PC_W-1:0]   i_pc,
  // Configuration words
  input  wire logic [CFG_W-1:0]  i_cfg_stored,
  input  wire logic [CFG_W-1:0]  i_cfg_shadow,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0] i_avs_address,
  input  wire logic              i_avs_read,
  input  wire logic              i_avs_write,
  input  wire logic [DATA_W-1:0] i_avs_writedata,
  output logic      [DATA_W-1:0] o_avs_readdata,
  output logic                   o_avs_waitrequest,
  // Core control
  output logic                   o_core_reset,
  output logic                   o_pc_load,
  output logic      [PC_W-1:0]   o_pc_value,
  output logic      [CFG_W-1:0]  o_cfg_active
);

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  rcpt_state_e              state_q;
  rcpt_state_e              state_d;
  logic [PUTM_W-1:0]        putm_cnt_q;
  logic [7:0]               flags_q;
  logic                     sere_q;
  logic [DATA_W-1:0]        scratch_q;
  logic                     wait_q;
  logic [DATA_W-1:0]        rdata_q;
  logic                     core_reset_q;
  logic                     pc_load_q;
  logic [PC_W-1:0]          pc_value_q;
  logic [CFG_W-1:0]         cfg_q;
  logic [DATA_W-1:0]        rdata_d;
  logic                     bus_wr;
  logic                     power_hold;
  logic                     in_run;
  logic                     idle;
  logic                     mismatch;
  logic                     ev_cf;
  logic                     ev_pinr;
  logic                     ev_wdt_rst;
  logic                     ev_wdt_wake;
  logic                     ev_rinst;
  logic                     ev_full;
  logic                     ev_unf;
  logic                     ev_irq;
  logic                     hard_rst;
  logic                     putm_done;

  ////////////////////////////////////////////////////////////////////////
  // Event decode, one winner per cycle by fixed priority

  // Power events override everything; regulator off masks brown-out
  assign power_hold = i_power_on | (i_brownout & i_vreg_enable);
  assign in_run     = (state_q == ST_RUN);
  assign idle       = (i_pm_mode == PM_IDLE);
  // Shadow holds the complement of the active words
  assign mismatch   = (cfg_q != ~i_cfg_shadow);
  assign putm_done  = i_internal_rc_osc_tick & (putm_cnt_q == PUTM_LAST);

  // Priority chain keeps simultaneous events from double-counting
  always_comb
  begin
    ev_cf       = 1'b0;
    ev_pinr     = 1'b0;
    ev_wdt_rst  = 1'b0;
    ev_wdt_wake = 1'b0;
    ev_rinst    = 1'b0;
    ev_full     = 1'b0;
    ev_unf      = 1'b0;
    ev_irq      = 1'b0;
    if (in_run && !power_hold)
    begin
      if (mismatch)
        ev_cf = 1'b1;
      else if (!i_master_clear_pin_n)
        ev_pinr = 1'b1;
      else if (i_watchdog_expiry)
      begin
        ev_wdt_rst  = !idle;
        ev_wdt_wake = idle;
      end
      else if (i_reset_instr)
        ev_rinst = 1'b1;
      else if (i_stack_full && sere_q)
        ev_full = 1'b1;
      else if (i_stack_underflow)
        ev_unf = 1'b1;
      else if (i_irq_wake && idle)
        ev_irq = 1'b1;
    end
  end

  // Internal resets that pulse the core without leaving run state
  assign hard_rst = ev_cf | ev_wdt_rst | ev_rinst | ev_full
                  | (ev_unf & sere_q);

  ////////////////////////////////////////////////////////////////////////
  // Sequencer and power-up timer

  // Next state; the timer has no enable, it runs on every power-up
  always_comb
  begin
    state_d = state_q;
    if (power_hold)
      state_d = ST_POWER;
    else
    begin
      case (state_q)
        ST_POWER: state_d = ST_TIMER;
        ST_TIMER:
          if (putm_done)
            state_d = i_master_clear_pin_n ? ST_RUN : ST_HOLD;
        ST_RUN:
          if (ev_pinr)
            state_d = ST_HOLD;
        ST_HOLD:
          if (i_master_clear_pin_n)
            state_d = ST_RUN;
        default: state_d = ST_POWER;
      endcase
    end
  end

  // State register
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
      state_q <= ST_POWER;
    else
      state_q <= state_d;
  end

  // Timer counts oscillator ticks only in timer state, cleared otherwise
  always_ff @(posedge i_clock)
  begin
    if (i_reset || state_q != ST_TIMER || power_hold)
      putm_cnt_q <= PUTM_ZERO;
    else if (i_internal_rc_osc_tick)
      putm_cnt_q <= putm_cnt_q + PUTM_ONE;
  end

  ////////////////////////////////////////////////////////////////////////
  // Cause and stack flags

  // Software writes first; hardware events later in the block win
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
      flags_q <= FLAGS_POR;
    else
    begin
      if (bus_wr && i_avs_address == REG_STATUS)
        flags_q <= (flags_q & ~FLAGS_SW_MSK)
                 | (i_avs_writedata[7:0] & FLAGS_SW_MSK);
      if (i_clrwdt_instr)
      begin
        flags_q[FLG_WDT]       <= 1'b1;
        flags_q[FLG_POWERDOWN] <= 1'b1;
      end
      if (i_sleep_instr)
      begin
        flags_q[FLG_WDT]       <= 1'b1;
        flags_q[FLG_POWERDOWN] <= 1'b0;
      end
      if (i_power_on)
        flags_q <= FLAGS_POR;
      else if (power_hold)
      begin
        flags_q[FLG_CFGMIS]    <= 1'b1;
        flags_q[FLG_RSTINSTR]  <= 1'b1;
        flags_q[FLG_WDT]       <= 1'b1;
        flags_q[FLG_POWERDOWN] <= 1'b1;
        flags_q[FLG_BROWNOUT]  <= 1'b0;
      end
      else if (ev_cf)
        flags_q[FLG_CFGMIS] <= 1'b0;
      else if (ev_pinr)
      begin
        // Full-power master clear touches no flag
        if (i_pm_mode != PM_FULL)
          flags_q[FLG_WDT] <= 1'b1;
        if (idle)
          flags_q[FLG_POWERDOWN] <= 1'b0;
      end
      else if (ev_wdt_rst)
        flags_q[FLG_WDT] <= 1'b0;
      else if (ev_wdt_wake)
      begin
        flags_q[FLG_WDT]       <= 1'b0;
        flags_q[FLG_POWERDOWN] <= 1'b0;
      end
      else if (ev_rinst)
        flags_q[FLG_RSTINSTR] <= 1'b0;
      else if (ev_full)
        flags_q[FLG_STKOVF] <= 1'b1;
      else if (ev_unf)
        flags_q[FLG_STKUDF] <= 1'b1;
      else if (ev_irq)
        flags_q[FLG_POWERDOWN] <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Core reset, program counter and configuration reload

  // Reset output follows the next state so it never lags the sequencer
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      core_reset_q <= 1'b1;
      pc_load_q    <= 1'b0;
      pc_value_q   <= PC_ZERO;
    end
    else
    begin
      core_reset_q <= (state_d != ST_RUN) | hard_rst;
      pc_load_q    <= 1'b0;
      if ((state_d == ST_RUN && !in_run) || hard_rst || ev_unf)
      begin
        pc_load_q  <= 1'b1;
        pc_value_q <= PC_ZERO;
      end
      else if (ev_wdt_wake)
      begin
        pc_load_q  <= 1'b1;
        pc_value_q <= PC_W'(i_pc + PC_STEP);
      end
      else if (ev_irq)
      begin
        pc_load_q <= 1'b1;
        if (i_irq_wake_high && i_high_prio_global_irq_en)
          pc_value_q <= VEC_HIGH;
        else if (i_low_prio_global_irq_en)
          pc_value_q <= VEC_LOW;
        else
          pc_value_q <= PC_W'(i_pc + PC_STEP);
      end
    end
  end

  // Active words reload while the core is held in any reset
  always_ff @(posedge i_clock)
  begin
    if (i_reset || state_d != ST_RUN || hard_rst)
      cfg_q <= i_cfg_stored;
  end

  ////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave, one wait state on every access

  assign bus_wr = i_avs_write & !wait_q;

  // Read mux; unmapped offsets read as zero
  always_comb
  begin
    rdata_d = '0;
    case (i_avs_address)
      REG_STATUS:  rdata_d[7:0] = flags_q;
      REG_CTRL:    rdata_d[CTRL_SERE_BIT] = sere_q;
      REG_TIMER:
      begin
        rdata_d[PUTM_W-1:0]           = putm_cnt_q;
        rdata_d[TMR_INRST_BIT]        = core_reset_q;
        rdata_d[TMR_STATE_LSB+:2]     = state_q;
      end
      REG_SCRATCH: rdata_d = scratch_q;
      default:     rdata_d = '0;
    endcase
  end

  // Waitrequest drops one cycle after the request, then rises again
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
    begin
      wait_q  <= 1'b1;
      rdata_q <= '0;
    end
    else if ((i_avs_read || i_avs_write) && wait_q)
    begin
      wait_q  <= 1'b0;
      rdata_q <= rdata_d;
    end
    else
      wait_q <= 1'b1;
  end

  // Stack-error reset enable
  always_ff @(posedge i_clock)
  begin
    if (i_reset)
      sere_q <= CTRL_SERE_RST;
    else if (bus_wr && i_avs_address == REG_CTRL)
      sere_q <= i_avs_writedata[CTRL_SERE_BIT];
  end

  // Scratch word has no reset value and survives every reset
  always_ff @(posedge i_clock)
  begin
    if (bus_wr && i_avs_address == REG_SCRATCH)
      scratch_q <= i_avs_writedata;
  end

  // Outputs straight from flops
  assign o_avs_readdata    = rdata_q;
  assign o_avs_waitrequest = wait_q;
  assign o_core_reset      = core_reset_q;
  assign o_pc_load         = pc_load_q;
  assign o_pc_value        = pc_value_q;
  assign o_cfg_active      = cfg_q;

  ////////////////////////////////////////////////////////////////////////
  // Assertions and covers

  AST_POR_FLAGS: assert property (@(posedge i_clock) disable iff (i_reset)
    i_power_on |=> flags_q == FLAGS_POR && core_reset_q)
    else $error("power-on flags wrong");

  AST_BRN_CLEAR: assert property (@(posedge i_clock) disable iff (i_reset)
    power_hold |=> !flags_q[FLG_BROWNOUT])
    else $error("brown-out flag not cleared");

  AST_VREG_OFF: assert property (@(posedge i_clock) disable iff (i_reset)
    in_run && !i_vreg_enable && !i_power_on |=> state_q != ST_POWER)
    else $error("brown-out acted with regulator off");

  AST_CF_RESET: assert property (@(posedge i_clock) disable iff (i_reset)
    in_run && !power_hold && mismatch
    |=> !flags_q[FLG_CFGMIS] && core_reset_q && pc_load_q)
    else $error("mismatch reset missing");

  AST_CF_KEEP: assert property (@(posedge i_clock) disable iff (i_reset)
    !power_hold && !ev_cf && !bus_wr |=> $stable(flags_q[FLG_CFGMIS]))
    else $error("mismatch flag changed");

  AST_RELOAD: assert property (@(posedge i_clock) disable iff (i_reset)
    hard_rst |=> cfg_q == $past(i_cfg_stored))
    else $error("configuration not reloaded");

  AST_HOLD: assert property (@(posedge i_clock) disable iff (i_reset)
    state_q != ST_RUN |-> core_reset_q)
    else $error("core released outside run");

  AST_TMR_START: assert property (@(posedge i_clock) disable iff (i_reset)
    power_hold |=> putm_cnt_q == PUTM_ZERO ##1 putm_cnt_q == PUTM_ZERO)
    else $error("timer started during power pulse");

  AST_PIN_GO: assert property (@(posedge i_clock) disable iff (i_reset)
    state_q == ST_HOLD && i_master_clear_pin_n && !power_hold
    |=> !core_reset_q && pc_load_q && pc_value_q == PC_ZERO)
    else $error("late master clear release did not start");

  AST_WDT_WAKE: assert property (@(posedge i_clock) disable iff (i_reset)
    ev_wdt_wake |=> !core_reset_q && pc_value_q == $past(i_pc) + PC_STEP
    && !flags_q[FLG_WDT] && !flags_q[FLG_POWERDOWN])
    else $error("watchdog wake wrong");

  AST_UNF: assert property (@(posedge i_clock) disable iff (i_reset)
    ev_unf && !sere_q |=> flags_q[FLG_STKUDF] && pc_load_q
    && !core_reset_q)
    else $error("underflow without reset wrong");

  COV_POWERUP: cover property (@(posedge i_clock) disable iff (i_reset)
    state_q == ST_TIMER ##1 state_q == ST_RUN);
  COV_LATE_PIN: cover property (@(posedge i_clock) disable iff (i_reset)
    state_q == ST_HOLD ##1 state_q == ST_RUN);
  COV_IRQ_VEC: cover property (@(posedge i_clock) disable iff (i_reset)
    ev_irq ##1 pc_value_q == VEC_LOW);

endmodule : rcpt_top

// file: tb/rcpt_supply_model.sv
// Far-side model: supply monitor, master clear pin and internal oscillator.
// Assumes the bench requests events by level; outputs change on clock edges.
`timescale 1ns/1ps

module rcpt_supply_model (
  // Clock
  input  wire logic i_clock,
  // Requests from the bench
  input  wire logic i_por_req,
  input  wire logic i_dip_req,
  input  wire logic i_pin_req,
  // Pins towards the block
  output logic      o_power_on,
  output logic      o_brownout,
  output logic      o_master_clear_pin_n,
  output logic      o_rc_tick
);
  logic por_q  = 1'b1;
  logic dip_q  = 1'b0;
  logic pin_q  = 1'b1;
  logic div_q  = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Supply is up only after the ramp request drops; the pin has a pull-up,
  // so a released pin reads high rather than holding an old value
  always @(posedge i_clock)
  begin
    por_q <= i_por_req;
    dip_q <= i_dip_req;
    pin_q <= ~i_pin_req;
    div_q <= ~div_q;
  end

  // Oscillator runs free, one tick every second clock to keep runs short
  assign o_power_on           = por_q;
  assign o_brownout           = dip_q;
  assign o_master_clear_pin_n = pin_q;
  assign o_rc_tick            = div_q;

endmodule : rcpt_supply_model

// file: tb/tb_reset_cause_and_powerup_timer.sv
// Self-checking bench for the reset-cause and power-up timer block.
// Assumes the supply model drives the pins and the bench drives the rest.
`timescale 1ns/1ps

module tb_reset_cause_and_powerup_timer;
  import rcpt_pkg::*;
  localparam int TMO_CYCLES = 40000;

  logic              i_clock = 1'b0;
  logic              i_reset = 1'b1;
  logic              i_power_on, i_brownout, i_master_clear_pin_n;
  logic              i_internal_rc_osc_tick;
  logic              i_vreg_enable = 1'b1;
  logic [1:0]        i_pm_mode = PM_FULL;
  logic              i_watchdog_expiry = 1'b0;
  logic              i_reset_instr = 1'b0;
  logic              i_clrwdt_instr = 1'b0;
  logic              i_sleep_instr = 1'b0;
  logic              i_stack_full = 1'b0;
  logic              i_stack_underflow = 1'b0;
  logic              i_irq_wake = 1'b0;
  logic              i_irq_wake_high = 1'b0;
  logic              i_high_prio_global_irq_en = 1'b0;
  logic              i_low_prio_global_irq_en = 1'b0;
  logic [PC_W-1:0]   i_pc = 21'h001234;
  logic [CFG_W-1:0]  i_cfg_stored = 16'h1234;
  logic [CFG_W-1:0]  i_cfg_shadow = 16'hEDCB;
  logic [ADDR_W-1:0] i_avs_address = 4'h0;
  logic              i_avs_read = 1'b0;
  logic              i_avs_write = 1'b0;
  logic [DATA_W-1:0] i_avs_writedata = 32'h0;
  logic [DATA_W-1:0] o_avs_readdata;
  logic              o_avs_waitrequest, o_core_reset, o_pc_load;
  logic [PC_W-1:0]   o_pc_value;
  logic [CFG_W-1:0]  o_cfg_active;
  logic              por_req = 1'b1;
  logic              dip_req = 1'b0;
  logic              pin_req = 1'b0;
  int                miscompares = 0;
  int                total_checks = 0;
  int                cycles = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Design and far-side model
  rcpt_top dut_u (.i_clock, .i_reset, .i_power_on, .i_brownout,
    .i_vreg_enable, .i_master_clear_pin_n, .i_internal_rc_osc_tick,
    .i_pm_mode, .i_watchdog_expiry, .i_reset_instr, .i_clrwdt_instr,
    .i_sleep_instr, .i_stack_full, .i_stack_underflow, .i_irq_wake,
    .i_irq_wake_high, .i_high_prio_global_irq_en,
    .i_low_prio_global_irq_en, .i_pc, .i_cfg_stored, .i_cfg_shadow,
    .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata,
    .o_avs_readdata, .o_avs_waitrequest, .o_core_reset, .o_pc_load,
    .o_pc_value, .o_cfg_active);

  rcpt_supply_model model_u (.i_clock, .i_por_req(por_req),
    .i_dip_req(dip_req), .i_pin_req(pin_req), .o_power_on(i_power_on),
    .o_brownout(i_brownout), .o_master_clear_pin_n(i_master_clear_pin_n),
    .o_rc_tick(i_internal_rc_osc_tick));

  // Clock and hang guard
  always #12.5 i_clock = ~i_clock;

  always @(posedge i_clock)
  begin
    cycles = cycles + 1;
    if (cycles == TMO_CYCLES)
    begin
      miscompares = miscompares + 1;
      test_done();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparison, bus and closing tasks
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks = total_checks + 1;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      miscompares = miscompares + 1;
    end
  endtask : chk

  // Request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    @(posedge i_clock);
    i_avs_address   <= a;
    i_avs_write     <= wr;
    i_avs_read      <= ~wr;
    i_avs_writedata <= d;
    @(posedge i_clock);
    while (o_avs_waitrequest !== 1'b0) @(posedge i_clock);
    q = o_avs_readdata;
    i_avs_read  <= 1'b0;
    i_avs_write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rdc(input string nm, input logic [3:0] a,
                     input logic [31:0] m, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, e, q & m);
  endtask : rdc

  // Counts oscillator ticks after the supply settles until the core starts
  task automatic wait_up();
    int n;
    n = 0;
    @(posedge i_clock);
    while (o_core_reset !== 1'b0)
    begin
      if (i_internal_rc_osc_tick === 1'b1 && i_power_on === 1'b0
          && i_brownout === 1'b0) n++;
      @(posedge i_clock);
    end
    chk("putm_ticks", 32'h1, {31'h0, n >= 2048 && n <= 2049});
    chk("pc_load", 32'h1, {31'h0, o_pc_load});
    chk("pc_value", 32'h0, {11'h0, o_pc_value});
  endtask : wait_up

  task test_done;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////////////////
  // One core event: c selects the source, irq is {high, high en, low en},
  // pk selects the expected restart address, 4 meaning no restart at all
  task automatic ev(input int c, input logic [1:0] m, input logic se,
    input logic [2:0] irq, input logic [7:0] es, input int pk,
    input logic rs);
    logic [20:0] pcv, epc;
    logic        seen;
    pcv  = '1;
    seen = 1'b0;
    epc  = (pk == 0) ? PC_ZERO : (pk == 1) ? i_pc + PC_STEP :
           (pk == 2) ? VEC_HIGH : (pk == 3) ? VEC_LOW : '1;
    wr(REG_CTRL, {31'h0, se});
    @(posedge i_clock);
    i_pm_mode <= m;
    {i_irq_wake_high, i_high_prio_global_irq_en,
     i_low_prio_global_irq_en} <= irq;
    @(posedge i_clock);
    case (c)
      0: i_watchdog_expiry <= 1'b1;
      1: pin_req <= 1'b1;
      2: i_reset_instr <= 1'b1;
      3: i_stack_full <= 1'b1;
      4: i_stack_underflow <= 1'b1;
      5: i_irq_wake <= 1'b1;
      6: {i_cfg_stored, i_cfg_shadow} <= {16'h5AC3, 16'hA53C};
      8: i_sleep_instr <= 1'b1;
      default: i_clrwdt_instr <= 1'b1;
    endcase
    @(posedge i_clock);
    {i_watchdog_expiry, i_reset_instr, i_stack_full, i_stack_underflow,
     i_irq_wake, i_clrwdt_instr, i_sleep_instr} <= '0;
    for (int n = 0; n < 30; n++)
    begin
      @(posedge i_clock);
      if (o_core_reset === 1'b1) seen = 1'b1;
      if (o_pc_load === 1'b1) pcv = o_pc_value;
      if (n == 3) pin_req <= 1'b0;
    end
    chk("pc_value", {11'h0, epc}, {11'h0, pcv});
    chk("core_reset", {31'h0, rs}, {31'h0, seen});
    rdc("status", REG_STATUS, 32'hFF, {24'h0, es});
    if (c == 6) chk("cfg_active", 32'h5AC3, {16'h0, o_cfg_active});
  endtask : ev

  ////////////////////////////////////////////////////////////////////////////
  // Scenario: register reset values, unmapped read, scratch storage
  task automatic t_regs();
    rdc("ctrl", REG_CTRL, 32'hFFFFFFFF, 32'h1);
    rdc("unmapped", 4'h2, 32'hFFFFFFFF, 32'h0);
    wr(REG_SCRATCH, 32'hA5A55A5A);
    rdc("scratch", REG_SCRATCH, 32'hFFFFFFFF, 32'hA5A55A5A);
    $display("test regs done");
  endtask : t_regs

  // Scenario: timer idle during the ramp, then full count and cause flags
  task automatic t_powerup();
    rdc("timer_idle", REG_TIMER, 32'h7FF, 32'h0);
    @(posedge i_clock);
    por_req <= 1'b0;
    wait_up();
    rdc("status", REG_STATUS, 32'hFF, {24'h0, FLAGS_POR});
    rdc("scratch", REG_SCRATCH, 32'hFFFFFFFF, 32'hA5A55A5A);
    $display("test powerup done");
  endtask : t_powerup

  // Scenario: every cause row, chained so each flag change is visible
  task automatic t_causes();
    wr(REG_STATUS, 32'h33);
    ev(0, PM_FULL, 1'b1, 3'b000, 8'h37, 0, 1'b1);
    ev(1, PM_RUN,  1'b1, 3'b000, 8'h3F, 0, 1'b1);
    ev(0, PM_RUN,  1'b1, 3'b000, 8'h37, 0, 1'b1);
    ev(1, PM_IDLE, 1'b1, 3'b000, 8'h3B, 0, 1'b1);
    ev(7, PM_FULL, 1'b1, 3'b000, 8'h3F, 4, 1'b0);
    ev(0, PM_IDLE, 1'b1, 3'b000, 8'h33, 1, 1'b0);
    ev(8, PM_FULL, 1'b1, 3'b000, 8'h3B, 4, 1'b0);
    ev(7, PM_FULL, 1'b1, 3'b000, 8'h3F, 4, 1'b0);
    ev(5, PM_IDLE, 1'b1, 3'b000, 8'h3B, 1, 1'b0);
    ev(5, PM_IDLE, 1'b1, 3'b110, 8'h3B, 2, 1'b0);
    ev(5, PM_IDLE, 1'b1, 3'b001, 8'h3B, 3, 1'b0);
    ev(1, PM_FULL, 1'b1, 3'b000, 8'h3B, 0, 1'b1);
    ev(2, PM_FULL, 1'b1, 3'b000, 8'h2B, 0, 1'b1);
    ev(3, PM_FULL, 1'b1, 3'b000, 8'hAB, 0, 1'b1);
    ev(4, PM_FULL, 1'b1, 3'b000, 8'hEB, 0, 1'b1);
    ev(6, PM_FULL, 1'b1, 3'b000, 8'hCB, 0, 1'b1);
    wr(REG_STATUS, 32'h00);
    ev(4, PM_FULL, 1'b0, 3'b000, 8'h48, 0, 1'b0);
    $display("test causes done");
  endtask : t_causes

  // Scenario: pin held low past timer expiry, start on release
  task automatic t_pin_hold();
    int n;
    n = 0;
    @(posedge i_clock);
    pin_req <= 1'b1;
    por_req  <= 1'b1;
    repeat (10) @(posedge i_clock);
    por_req <= 1'b0;
    repeat (4300) @(posedge i_clock);
    rdc("timer_hold", REG_TIMER, 32'h70000, 32'h50000);
    @(posedge i_clock);
    pin_req <= 1'b0;
    while (o_core_reset !== 1'b0 && n < 8)
    begin
      @(posedge i_clock);
      n++;
    end
    chk("pin_start", 32'h1, {31'h0, n <= 4});
    rdc("status", REG_STATUS, 32'hFF, {24'h0, FLAGS_POR});
    $display("test pin_hold done");
  endtask : t_pin_hold

  // Scenario: dip during the timer, then regulator off and power-on
  task automatic t_brownout();
    wr(REG_STATUS, 32'hFF);
    @(posedge i_clock);
    dip_req <= 1'b1;
    repeat (5) @(posedge i_clock);
    dip_req <= 1'b0;
    repeat (1000) @(posedge i_clock);
    dip_req <= 1'b1;
    repeat (5) @(posedge i_clock);
    dip_req <= 1'b0;
    wait_up();
    rdc("status", REG_STATUS, 32'hFF, 32'hFE);
    rdc("scratch", REG_SCRATCH, 32'hFFFFFFFF, 32'hA5A55A5A);
    i_vreg_enable <= 1'b0;
    wr(REG_STATUS, 32'hFF);
    @(posedge i_clock);
    dip_req <= 1'b1;
    repeat (20) @(posedge i_clock);
    chk("core_reset", 32'h0, {31'h0, o_core_reset});
    dip_req <= 1'b0;
    rdc("status", REG_STATUS, 32'hFF, 32'hFF);
    @(posedge i_clock);
    por_req <= 1'b1;
    repeat (5) @(posedge i_clock);
    por_req <= 1'b0;
    wait_up();
    rdc("status", REG_STATUS, 32'hFF, {24'h0, FLAGS_POR});
    i_vreg_enable <= 1'b1;
    $display("test brownout done");
  endtask : t_brownout

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (8) @(posedge i_clock);
    i_reset <= 1'b0;
    t_regs();
    t_powerup();
    t_causes();
    t_pin_hold();
    t_brownout();
    test_done();
  end

endmodule : tb_reset_cause_and_powerup_timer
